// >>> core/irq_unit_pkg.sv
package irq_unit_pkg;
    // Register bit positions, first control register.
    localparam int GIE_BIT      = 0;
    localparam int PIN_EN_BIT   = 1;
    localparam int T0_EN_BIT    = 2;
    localparam int SRC3_EN_BIT  = 3;
    localparam int PIN_FLAG_BIT = 4;
    localparam int T0_FLAG_BIT  = 5;
    localparam int SRC3_FLAG_BIT = 6;
    // Register bit positions, second control register.
    localparam int TB_EN_BIT    = 0;
    localparam int TB_FLAG_BIT  = 4;
    // Edge select field position in the misc control register.
    localparam int EDGE_LSB_BIT = 6;
    localparam int EDGE_MSB_BIT = 7;
    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] EDGE_RESET = 2'h0;
    localparam logic [7:0] PC_RESET   = 8'h00;
    // Edge select encodings.
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Vector addresses.
    localparam logic [7:0] VEC_PIN = 8'h04;
    localparam logic [7:0] VEC_T0  = 8'h08;
    localparam logic [7:0] VEC_0C  = 8'h0C;
    localparam logic [7:0] VEC_10  = 8'h10;
    localparam logic [7:0] VEC_14  = 8'h14;
    // Latency in clock cycles from acceptance to vector jump.
    localparam int RUN_LATENCY  = 2;
    localparam int WAKE_LATENCY = 3;
    localparam logic [1:0] RUN_WAIT  = 2'(RUN_LATENCY - 1);
    localparam logic [1:0] WAKE_WAIT = 2'(WAKE_LATENCY - 1);
    // Sequencer states.
    typedef enum logic [1:0] {IDLE, WAIT_JUMP} seq_t;
endpackage : irq_unit_pkg

// >>> core/mcu_vectored_interrupt_unit.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - One pin source plus timer and time-base sources, each with flag and enable.
// - A source event sets its flag; enabled flags form requests.
// - Global enable low blocks all servicing.
// - Acceptance pushes the next address and loads the vector.
// - Return instruction pops the saved address to resume.
// - Servicing clears the global enable, blocking nesting.
// - Requests during service still set and hold flags.
// - A full stack blocks acknowledging any request.
// - Running, the vector jump comes two cycles after acceptance.
// - Waking from sleep, the vector jump comes three cycles later.
// - Requests between phase-two pulses are taken on the latter pulse.
// - Four-source order: pin 04H, timer zero 08H, conversion 0CH, time base 10H.
// - Five-source order: pin, timer zero, timer one 0CH, conversion 10H, time base 14H.
// - Pin request beats internal requests when simultaneous.
// - Pin flag set by an edge; service needs global and pin enables.
// - Two-bit edge select at bits 6,7: off, rising, falling, both.
// - Pin acts as interrupt input only when enabled, edge chosen, input.
// - Servicing the pin clears its flag and the global enable.
// - Pull-high on the shared pin stays active in interrupt use.
// - First register: enables bits 0-3, flags bits 4-6, bit 7 zero.
// - Second register: time-base enable bit 0, flag bit 4.
module mcu_vectored_interrupt_unit
    import irq_unit_pkg::*;
#(
    parameter bit FIVE_SOURCE = 1'b0
) (
    // Clock and reset.
    input  wire logic       I_CLOCK,
    input  wire logic       I_RST_N,
    // Register write port.
    input  wire logic       I_CTRL_FIRST_WE,
    input  wire logic [7:0] I_CTRL_FIRST_WDATA,
    input  wire logic       I_CTRL_SECOND_WE,
    input  wire logic [7:0] I_CTRL_SECOND_WDATA,
    input  wire logic       I_MISC_CONTROL_WE,
    input  wire logic [7:0] I_MISC_CONTROL_WDATA,
    // Register read values.
    output logic [7:0]      O_IRQ_CTRL_FIRST,
    output logic [7:0]      O_IRQ_CTRL_SECOND,
    output logic [1:0]      O_EDGE_SELECT,
    // Shared pin and its direction bit.
    input  wire logic       I_PORT_A_PIN_THREE,
    input  wire logic       I_PORT_A_DIRECTION,
    input  wire logic       I_PULL_HIGH_SEL,
    output logic            O_PULL_HIGH_EN,
    // Source event pulses.
    input  wire logic       I_TIMER_ZERO_EVT,
    input  wire logic       I_TIMER_ONE_EVT,
    input  wire logic       I_CONVERSION_EVT,
    input  wire logic       I_TIME_BASE_EVT,
    // Core sequencer interface.
    input  wire logic       I_PHASE_TWO_PULSE,
    input  wire logic       I_SLEEP,
    input  wire logic       I_STACK_FULL,
    input  wire logic [7:0] I_NEXT_PC,
    input  wire logic       I_RETI,
    output logic            O_WAKE,
    output logic            O_STACK_PUSH,
    output logic [7:0]      O_PUSH_DATA,
    output logic            O_STACK_POP,
    output logic            O_PC_LOAD,
    output logic [7:0]      O_PC_VALUE
);

    // Vector of the given priority slot for the configured variant.
    function automatic logic [7:0] slot_vector(input logic [1:0] slot);
        logic [7:0] v;
        v = VEC_PIN;
        unique case (slot)
            2'h0: v = VEC_PIN;
            2'h1: v = VEC_T0;
            2'h2: v = VEC_0C;
            2'h3: v = FIVE_SOURCE ? VEC_10 : VEC_0C;
        endcase
        return v;
    endfunction : slot_vector

    // Register state.
    logic       gie;
    logic       pin_en;
    logic       t0_en;
    logic       src3_en;
    logic       pin_flag;
    logic       t0_flag;
    logic       src3_flag;
    logic       tb_en;
    logic       tb_flag;
    logic [1:0] edge_sel;
    logic       pin_prev;
    logic       next_gie;
    logic       next_pin_en;
    logic       next_t0_en;
    logic       next_src3_en;
    logic       next_pin_flag;
    logic       next_t0_flag;
    logic       next_src3_flag;
    logic       next_tb_en;
    logic       next_tb_flag;
    logic [1:0] next_edge_sel;
    // Timer one in the five-source part; conversion in the four-source part.
    logic       src3_evt;
    logic       pin_edge;
    logic       pin_active;
    logic       pin_req;
    logic       t0_req;
    logic       src3_req;
    logic       tb_req;
    logic       any_req;
    logic       accept;
    // Five-source part keeps the conversion source in the second register.
    logic       cv_en;
    logic       cv_flag;
    logic       cv_req;
    logic       next_cv_en;
    logic       next_cv_flag;
    // Sequencer state.
    seq_t       state;
    seq_t       next_state;
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic [7:0] vector;
    logic [7:0] next_vector;
    logic [2:0] win;
    logic       next_push;
    logic [7:0] next_push_data;
    logic       next_load;
    logic       next_wake;

    assign src3_evt = FIVE_SOURCE ? I_TIMER_ONE_EVT : I_CONVERSION_EVT;

    assign pin_active = pin_en && (edge_sel != EDGE_OFF) && I_PORT_A_DIRECTION; // A set direction bit means input.

    always_comb begin
        unique case (edge_sel)
            EDGE_OFF:  pin_edge = 1'b0;
            EDGE_RISE: pin_edge = I_PORT_A_PIN_THREE && !pin_prev;
            EDGE_FALL: pin_edge = !I_PORT_A_PIN_THREE && pin_prev;
            EDGE_BOTH: pin_edge = I_PORT_A_PIN_THREE != pin_prev;
        endcase
    end

    assign pin_req  = pin_flag && pin_en;
    assign t0_req   = t0_flag && t0_en;
    assign src3_req = src3_flag && src3_en;
    assign cv_req   = FIVE_SOURCE && cv_flag && cv_en;
    assign tb_req   = tb_flag && tb_en;
    assign any_req  = pin_req || t0_req || src3_req || cv_req || tb_req;

    assign accept = (state == IDLE) && I_PHASE_TWO_PULSE && gie && any_req && !I_STACK_FULL;

    always_comb begin
        win = 3'h4;
        if (pin_req) begin
            win = 3'h0;
        end else if (t0_req) begin
            win = 3'h1;
        end else if (src3_req) begin
            win = 3'h2;
        end else if (cv_req) begin
            win = 3'h3;
        end
    end

    // Flag and enable next values; hardware set wins over a software clear.
    always_comb begin
        next_gie       = gie;
        next_pin_en    = pin_en;
        next_t0_en     = t0_en;
        next_src3_en   = src3_en;
        next_pin_flag  = pin_flag;
        next_t0_flag   = t0_flag;
        next_src3_flag = src3_flag;
        next_tb_en     = tb_en;
        next_tb_flag   = tb_flag;
        next_cv_en     = cv_en;
        next_cv_flag   = cv_flag;
        next_edge_sel  = edge_sel;
        if (I_CTRL_FIRST_WE) begin
            next_gie       = I_CTRL_FIRST_WDATA[GIE_BIT];
            next_pin_en    = I_CTRL_FIRST_WDATA[PIN_EN_BIT];
            next_t0_en     = I_CTRL_FIRST_WDATA[T0_EN_BIT];
            next_src3_en   = I_CTRL_FIRST_WDATA[SRC3_EN_BIT];
            next_pin_flag  = I_CTRL_FIRST_WDATA[PIN_FLAG_BIT];
            next_t0_flag   = I_CTRL_FIRST_WDATA[T0_FLAG_BIT];
            next_src3_flag = I_CTRL_FIRST_WDATA[SRC3_FLAG_BIT];
        end
        if (I_CTRL_SECOND_WE) begin
            next_tb_en   = I_CTRL_SECOND_WDATA[TB_EN_BIT];
            next_tb_flag = I_CTRL_SECOND_WDATA[TB_FLAG_BIT];
            next_cv_en   = FIVE_SOURCE && I_CTRL_SECOND_WDATA[1];
            next_cv_flag = FIVE_SOURCE && I_CTRL_SECOND_WDATA[5];
        end
        if (I_MISC_CONTROL_WE) begin
            next_edge_sel = {I_MISC_CONTROL_WDATA[EDGE_MSB_BIT], I_MISC_CONTROL_WDATA[EDGE_LSB_BIT]};
        end
        if (accept) begin
            next_gie = 1'b0;
            unique case (win)
                3'h0: next_pin_flag = 1'b0;
                3'h1: next_t0_flag = 1'b0;
                3'h2: next_src3_flag = 1'b0;
                3'h3: next_cv_flag = 1'b0;
                default: next_tb_flag = 1'b0;
            endcase
        end
        next_pin_flag  = next_pin_flag || (pin_active && pin_edge);
        next_t0_flag   = next_t0_flag || I_TIMER_ZERO_EVT;
        next_src3_flag = next_src3_flag || src3_evt;
        next_cv_flag   = next_cv_flag || (FIVE_SOURCE && I_CONVERSION_EVT);
        next_tb_flag   = next_tb_flag || I_TIME_BASE_EVT;
    end

    // Register the flags and enables; all clear at power-on.
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            gie       <= 1'b0;
            pin_en    <= 1'b0;
            t0_en     <= 1'b0;
            src3_en   <= 1'b0;
            pin_flag  <= 1'b0;
            t0_flag   <= 1'b0;
            src3_flag <= 1'b0;
            tb_en     <= 1'b0;
            tb_flag   <= 1'b0;
            cv_en     <= 1'b0;
            cv_flag   <= 1'b0;
            edge_sel  <= EDGE_RESET;
            pin_prev  <= 1'b0;
        end else begin
            gie       <= next_gie;
            pin_en    <= next_pin_en;
            t0_en     <= next_t0_en;
            src3_en   <= next_src3_en;
            pin_flag  <= next_pin_flag;
            t0_flag   <= next_t0_flag;
            src3_flag <= next_src3_flag;
            tb_en     <= next_tb_en;
            tb_flag   <= next_tb_flag;
            cv_en     <= next_cv_en;
            cv_flag   <= next_cv_flag;
            edge_sel  <= next_edge_sel;
            pin_prev  <= I_PORT_A_PIN_THREE;
        end
    end

    // Sequencer next values: accept, wait out the latency, then jump.
    always_comb begin
        next_state     = state;
        next_wait_cnt  = wait_cnt;
        next_vector    = vector;
        next_push      = 1'b0;
        next_push_data = O_PUSH_DATA;
        next_load      = 1'b0;
        next_wake      = 1'b0;
        unique case (state)
            IDLE: begin
                // A wake request does not need the global enable.
                next_wake = I_SLEEP && any_req;
                if (accept) begin
                    next_wait_cnt = I_SLEEP ? WAKE_WAIT : RUN_WAIT;
                    next_vector   = (win == 3'h4) ? (FIVE_SOURCE ? VEC_14 : VEC_10) : slot_vector(win[1:0]);
                    next_state    = WAIT_JUMP;
                end
            end
            WAIT_JUMP: begin
                if (wait_cnt == 2'h1) begin
                    next_push      = 1'b1;
                    next_push_data = I_NEXT_PC;
                    next_load      = 1'b1;
                    next_state     = IDLE;
                end
                next_wait_cnt = wait_cnt - 2'h1;
            end
        endcase
    end

    // Register the sequencer and the stack, jump, wake, pop and pull-high outputs.
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state          <= IDLE;
            wait_cnt       <= 2'h0;
            vector         <= PC_RESET;
            O_STACK_PUSH   <= 1'b0;
            O_PUSH_DATA    <= PC_RESET;
            O_PC_LOAD      <= 1'b0;
            O_PC_VALUE     <= PC_RESET;
            O_WAKE         <= 1'b0;
            O_STACK_POP    <= 1'b0;
            O_PULL_HIGH_EN <= 1'b0;
        end else begin
            state          <= next_state;
            wait_cnt       <= next_wait_cnt;
            vector         <= next_vector;
            O_STACK_PUSH   <= next_push;
            O_PUSH_DATA    <= next_push_data;
            O_PC_LOAD      <= next_load;
            O_PC_VALUE     <= next_load ? vector : O_PC_VALUE;
            O_WAKE         <= next_wake;
            O_STACK_POP    <= I_RETI;
            O_PULL_HIGH_EN <= I_PULL_HIGH_SEL;
        end
    end

    // register read images; unimplemented bits read zero.
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_IRQ_CTRL_FIRST  <= CTRL_RESET;
            O_IRQ_CTRL_SECOND <= CTRL_RESET;
            O_EDGE_SELECT     <= EDGE_RESET;
        end else begin
            O_IRQ_CTRL_FIRST  <= {1'b0, next_src3_flag, next_t0_flag, next_pin_flag,
                                  next_src3_en, next_t0_en, next_pin_en, next_gie};
            O_IRQ_CTRL_SECOND <= {2'h0, next_cv_flag, next_tb_flag, 2'h0, next_cv_en, next_tb_en};
            O_EDGE_SELECT     <= next_edge_sel;
        end
    end

endmodule : mcu_vectored_interrupt_unit
`default_nettype wire

// >>> tb/core_stack_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_stack_model #(
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    // Stack traffic from the interrupt unit.
    input  wire logic       i_push,
    input  wire logic       i_pop,
    // Sequencer outputs.
    output logic            o_phase_two,
    output logic            o_stack_full,
    output logic [7:0]      o_next_pc
);
    logic [1:0] phase;
    int         depth;
    // Sampling pulse every fourth cycle, so requests must wait for the next pulse.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= 2'h0;
            depth <= 0;
            o_next_pc <= 8'h00;
        end else begin
            phase <= phase + 2'h1;
            o_next_pc <= o_next_pc + 8'h01;
            depth <= depth + int'(i_push) - int'(i_pop);
        end
    end
    // A small stack fills fast, which is how the full case is reached.
    assign o_phase_two = (phase == 2'h3);
    assign o_stack_full = (depth >= DEPTH);
endmodule : core_stack_model
`default_nettype wire

// >>> tb/irq_unit_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module irq_unit_checker
    import irq_unit_pkg::*;
#(
    parameter bit FIVE_SOURCE = 1'b0
) (
    // Watched ports.
    input wire logic       I_CLOCK,
    input wire logic       I_RST_N,
    input wire logic [7:0] O_IRQ_CTRL_FIRST,
    input wire logic [7:0] O_IRQ_CTRL_SECOND,
    input wire logic       I_PHASE_TWO_PULSE,
    input wire logic       I_SLEEP,
    input wire logic       I_STACK_FULL,
    input wire logic       I_RETI,
    input wire logic       O_STACK_POP,
    input wire logic       O_STACK_PUSH,
    input wire logic       O_PC_LOAD,
    input wire logic [7:0] O_PC_VALUE
);
    logic [4:0] hit;
    logic       take;
    logic [7:0] win;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    // Enabled pending sources, pin first; take marks an acceptance edge.
    always_comb begin
        hit[0] = O_IRQ_CTRL_FIRST[PIN_EN_BIT] & O_IRQ_CTRL_FIRST[PIN_FLAG_BIT];
        hit[1] = O_IRQ_CTRL_FIRST[T0_EN_BIT] & O_IRQ_CTRL_FIRST[T0_FLAG_BIT];
        hit[2] = O_IRQ_CTRL_FIRST[SRC3_EN_BIT] & O_IRQ_CTRL_FIRST[SRC3_FLAG_BIT];
        hit[3] = FIVE_SOURCE & O_IRQ_CTRL_SECOND[1] & O_IRQ_CTRL_SECOND[5];
        hit[4] = O_IRQ_CTRL_SECOND[TB_EN_BIT] & O_IRQ_CTRL_SECOND[TB_FLAG_BIT];
        take = I_PHASE_TWO_PULSE & O_IRQ_CTRL_FIRST[GIE_BIT] & (|hit) & !I_STACK_FULL;
        win = hit[0] ? VEC_PIN : hit[1] ? VEC_T0 : hit[2] ? VEC_0C : hit[3] ? VEC_10 :
              (FIVE_SOURCE ? VEC_14 : VEC_10);
    end
    push_load_pair_a: assert property (O_STACK_PUSH == O_PC_LOAD)
        else $error("push and load differ");
    pop_on_return_a: assert property (I_RETI |=> O_STACK_POP)
        else $error("no pop after return");
    run_vector_a: assert property (take && !I_SLEEP |-> ##2 O_PC_LOAD && O_PC_VALUE == $past(win, 2))
        else $error("running jump late or wrong vector");
    wake_vector_a: assert property (take && I_SLEEP |-> ##3 O_PC_LOAD && O_PC_VALUE == $past(win, 3))
        else $error("wake jump late or wrong vector");
    gie_blocks_a: assert property (I_PHASE_TWO_PULSE && !O_IRQ_CTRL_FIRST[GIE_BIT] |-> ##2 !O_PC_LOAD [*2])
        else $error("jump with global enable off");
    full_blocks_a: assert property (I_PHASE_TWO_PULSE && I_STACK_FULL |-> ##2 !O_PC_LOAD [*2])
        else $error("jump with stack full");
    pulse_only_a: assert property (O_PC_LOAD |-> $past(I_PHASE_TWO_PULSE, 2) || $past(I_PHASE_TWO_PULSE, 3))
        else $error("jump not tied to sampling pulse");
    pin_clear_a: assert property (take && hit[0] |=> !O_IRQ_CTRL_FIRST[PIN_FLAG_BIT] && !O_IRQ_CTRL_FIRST[GIE_BIT])
        else $error("pin flag or global enable kept");
    others_kept_a: assert property (take && hit[0] && hit[1] |=> O_IRQ_CTRL_FIRST[T0_FLAG_BIT])
        else $error("lower request lost");
    unused_zero_a: assert property (!O_IRQ_CTRL_FIRST[7] && (O_IRQ_CTRL_SECOND & 8'hCC) == 8'h00)
        else $error("unimplemented bit set");
endmodule : irq_unit_checker
bind mcu_vectored_interrupt_unit irq_unit_checker #(.FIVE_SOURCE(FIVE_SOURCE)) chk_u (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .O_IRQ_CTRL_FIRST(O_IRQ_CTRL_FIRST),
    .O_IRQ_CTRL_SECOND(O_IRQ_CTRL_SECOND), .I_PHASE_TWO_PULSE(I_PHASE_TWO_PULSE), .I_SLEEP(I_SLEEP),
    .I_STACK_FULL(I_STACK_FULL), .I_RETI(I_RETI), .O_STACK_POP(O_STACK_POP), .O_STACK_PUSH(O_STACK_PUSH),
    .O_PC_LOAD(O_PC_LOAD), .O_PC_VALUE(O_PC_VALUE));
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import irq_unit_pkg::*;
;
    logic       clk, rst_n, we1, we2, wem, pin, dir, pull_sel, sleep, reti;
    logic [7:0] wd;
    logic [3:0] evts;
    wire logic [7:0] img1, img2, pc_val, push_d, next_pc, pc_f;
    wire logic [1:0] edge_sel;
    wire logic       pull_en, wake, push, pop, load, pt2, full, load_f;
    int         errors, samples_checked;
    // Unit under test, four-source variant.
    mcu_vectored_interrupt_unit #(.FIVE_SOURCE(1'b0)) dut_u (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_CTRL_FIRST_WE(we1), .I_CTRL_FIRST_WDATA(wd), .I_CTRL_SECOND_WE(we2), .I_CTRL_SECOND_WDATA(wd),
        .I_MISC_CONTROL_WE(wem), .I_MISC_CONTROL_WDATA(wd), .O_IRQ_CTRL_FIRST(img1), .O_IRQ_CTRL_SECOND(img2),
        .O_EDGE_SELECT(edge_sel), .I_PORT_A_PIN_THREE(pin), .I_PORT_A_DIRECTION(dir), .I_PULL_HIGH_SEL(pull_sel),
        .O_PULL_HIGH_EN(pull_en), .I_TIMER_ZERO_EVT(evts[0]), .I_TIMER_ONE_EVT(evts[1]),
        .I_CONVERSION_EVT(evts[2]), .I_TIME_BASE_EVT(evts[3]), .I_PHASE_TWO_PULSE(pt2), .I_SLEEP(sleep),
        .I_STACK_FULL(full), .I_NEXT_PC(next_pc), .I_RETI(reti), .O_WAKE(wake), .O_STACK_PUSH(push),
        .O_PUSH_DATA(push_d), .O_STACK_POP(pop), .O_PC_LOAD(load), .O_PC_VALUE(pc_val));
    // Five-source variant on the same stimulus; only its jumps are watched here.
    mcu_vectored_interrupt_unit #(.FIVE_SOURCE(1'b1)) dut_five_u (.I_CLOCK(clk), .I_RST_N(rst_n),
        .I_CTRL_FIRST_WE(we1), .I_CTRL_FIRST_WDATA(wd), .I_CTRL_SECOND_WE(we2), .I_CTRL_SECOND_WDATA(wd),
        .I_MISC_CONTROL_WE(wem), .I_MISC_CONTROL_WDATA(wd), .O_IRQ_CTRL_FIRST(), .O_IRQ_CTRL_SECOND(),
        .O_EDGE_SELECT(), .I_PORT_A_PIN_THREE(pin), .I_PORT_A_DIRECTION(dir), .I_PULL_HIGH_SEL(pull_sel),
        .O_PULL_HIGH_EN(), .I_TIMER_ZERO_EVT(evts[0]), .I_TIMER_ONE_EVT(evts[1]),
        .I_CONVERSION_EVT(evts[2]), .I_TIME_BASE_EVT(evts[3]), .I_PHASE_TWO_PULSE(pt2), .I_SLEEP(sleep),
        .I_STACK_FULL(full), .I_NEXT_PC(next_pc), .I_RETI(reti), .O_WAKE(), .O_STACK_PUSH(),
        .O_PUSH_DATA(), .O_STACK_POP(), .O_PC_LOAD(load_f), .O_PC_VALUE(pc_f));
    // Core model with a two-deep stack.
    core_stack_model #(.DEPTH(2)) core_u (.i_clock(clk), .i_rst_n(rst_n), .i_push(push), .i_pop(pop),
        .o_phase_two(pt2), .o_stack_full(full), .o_next_pc(next_pc));
    // Free-running clock, 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // Register write: r is 1 first, 2 second, 3 misc.
    task automatic wr(input int r, input logic [7:0] d);
        @(posedge clk);
        we1 <= (r == 1);
        we2 <= (r == 2);
        wem <= (r == 3);
        wd <= d;
        @(posedge clk);
        {we1, we2, wem} <= 3'h0;
    endtask : wr
    task automatic fire(input logic [3:0] e);
        @(posedge clk);
        evts <= e;
        @(posedge clk);
        evts <= 4'h0;
    endtask : fire
    task automatic ret();
        @(posedge clk);
        reti <= 1'b1;
        @(posedge clk);
        reti <= 1'b0;
        #1;
        chk({7'h00, pop}, 8'h01);
    endtask : ret
    // The jump must come with the vector and the address seen one cycle before it.
    task automatic expect_load(input logic [7:0] vec);
        int n;
        n = 0;
        do begin
            settle(1);
            n++;
        end while (load !== 1'b1 && n < 24);
        chk({7'h00, load}, 8'h01);
        chk({7'h00, push}, 8'h01);
        chk(pc_val, vec);
        chk(push_d, 8'(next_pc - 8'h01));
    endtask : expect_load
    task automatic expect_none(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            settle(1);
            seen = seen | (load === 1'b1);
        end
        chk({7'h00, seen}, 8'h00);
    endtask : expect_none
    task automatic t_regs();
        settle(1);
        chk(img1, CTRL_RESET);
        chk({6'h00, edge_sel}, {6'h00, EDGE_RESET});
        chk({7'h00, pull_en}, 8'h00);
        wr(1, 8'hF0);
        wr(2, 8'hFF);
        settle(1);
        chk(img1, 8'h70);
        chk(img2, 8'h11);
        wr(2, 8'h00);
    endtask : t_regs
    task automatic t_priority();
        logic [7:0] vecs [3];
        vecs = '{VEC_T0, VEC_0C, VEC_10};
        wr(3, {EDGE_RISE, 6'h00});
        wr(2, 8'h01);
        wr(1, 8'h0E);
        @(posedge clk);
        pin <= 1'b1;
        evts <= 4'b1101;
        @(posedge clk);
        evts <= 4'h0;
        settle(3);
        chk(img1, 8'h7E);
        wr(1, 8'h7F);
        expect_load(VEC_PIN);
        settle(1);
        chk(img1, 8'h6E);
        for (int i = 0; i < 3; i++) begin
            ret();
            wr(1, img1 | 8'h01);
            expect_load(vecs[i]);
        end
        ret();
        settle(2);
        chk(img2, 8'h01);
    endtask : t_priority
    task automatic t_block();
        wr(1, 8'h04);
        fire(4'h1);
        expect_none(16);
        wr(1, 8'h25);
        expect_load(VEC_T0);
        chk({7'h00, img1[GIE_BIT]}, 8'h00);
        wr(1, 8'h05);
        fire(4'h1);
        expect_load(VEC_T0);
        wr(1, 8'h05);
        fire(4'h1);
        expect_none(16);
        ret();
        expect_load(VEC_T0);
        ret();
        ret();
    endtask : t_block
    task automatic t_edges();
        pull_sel <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(3, {2'(s), 6'h00});
            wr(1, 8'h02);
            @(posedge clk);
            pin <= 1'b0;
            settle(4);
            chk({7'h00, img1[PIN_FLAG_BIT]}, {7'h00, s[1]});
            chk({6'h00, edge_sel}, {6'h00, 2'(s)});
            wr(1, 8'h02);
            @(posedge clk);
            pin <= 1'b1;
            settle(4);
            chk({7'h00, img1[PIN_FLAG_BIT]}, {7'h00, s[0]});
        end
        dir <= 1'b0;
        wr(1, 8'h02);
        @(posedge clk);
        pin <= 1'b0;
        settle(4);
        chk({7'h00, img1[PIN_FLAG_BIT]}, 8'h00);
        chk({7'h00, pull_en}, 8'h01);
        dir <= 1'b1;
    endtask : t_edges
    task automatic t_sleep();
        sleep <= 1'b1;
        wr(1, 8'h05);
        fire(4'h1);
        settle(1);
        chk({7'h00, wake}, 8'h01);
        expect_load(VEC_T0);
        chk({7'h00, wake}, 8'h00);
        sleep <= 1'b0;
        ret();
    endtask : t_sleep
    // Five-source order: timer one at 0C, conversion at 10, time base at 14.
    task automatic t_five();
        int n;
        wr(2, 8'h03);
        wr(1, 8'h08);
        fire(4'hE);
        wr(1, 8'h49);
        expect_load(VEC_0C);
        chk({7'h00, load_f}, 8'h01);
        chk(pc_f, VEC_0C);
        ret();
        wr(1, 8'h09);
        expect_load(VEC_10);
        chk(pc_f, VEC_10);
        ret();
        wr(1, 8'h09);
        n = 0;
        do begin
            settle(1);
            n++;
        end while (load_f !== 1'b1 && n < 24);
        chk(pc_f, VEC_14);
    endtask : t_five
    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test
    // Main sequence after a 12-cycle reset.
    initial begin
        {rst_n, we1, we2, wem, pin, pull_sel, sleep, reti} = '0;
        // The shared pin starts out configured as an input.
        dir = 1'b1;
        wd = 8'h00;
        evts = 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_priority();
        t_block();
        t_edges();
        t_sleep();
        t_five();
        end_of_test();
    end
    // Watchdog well beyond the expected run of under a thousand cycles.
    initial begin
        #(20 * 6000);
        errors++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
